/* common/ctcd_pkg.sv */
// Constants and types shared by the codec timing command decoder
package ctcd_pkg;
	// Clock and word framing
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          WORD_BITS      = 16;
	localparam logic [4:0]  LAST_BIT       = 5'h0F;
	// Command selector (low two bits of a word)
	localparam logic [1:0]  SEL_A_DIV      = 2'h0;
	localparam logic [1:0]  SEL_TRIM       = 2'h1;
	localparam logic [1:0]  SEL_B_DIV      = 2'h2;
	localparam logic [1:0]  SEL_CTRL       = 2'h3;
	// Primary word low bits: period adjust and secondary request
	localparam logic [1:0]  PRI_PLAIN      = 2'h0;
	localparam logic [1:0]  PRI_ADD        = 2'h1;
	localparam logic [1:0]  PRI_SUB        = 2'h2;
	localparam logic [1:0]  PRI_SECONDARY  = 2'h3;
	// Field positions inside a secondary word; DAC field of a primary word
	localparam int          XA_MSB = 13, XA_LSB = 9, RA_MSB = 6, RA_LSB = 2;
	localparam int          X6_MSB = 14, X6_LSB = 9, R6_MSB = 7, R6_LSB = 2;
	localparam int          C_HPF = 2, C_LOOP = 3, C_AUX = 4, C_SYNC = 5;
	localparam int          C_GAIN_LSB = 6, C_GAIN_MSB = 7, C_SINX = 9;
	localparam int          C_FLAG10 = 10, C_FLAG11 = 11;
	localparam int          DAC_MSB = 15, DAC_LSB = 2;
	// Reset values
	localparam logic [4:0]  A_DIV_RESET    = 5'h12;
	localparam logic [5:0]  B_DIV_RESET    = 6'h12;
	localparam logic [5:0]  TRIM_RESET     = 6'h01;
	localparam logic [1:0]  GAIN_RESET     = 2'h0;
	// Programming limits
	localparam logic [4:0]  A_MIN_WORD     = 5'h04;
	localparam logic [4:0]  A_MIN_BYTE     = 5'h05;
	localparam logic [4:0]  A_DEAD_MAX     = 5'h01;
	localparam logic [5:0]  B_MIN          = 6'h0F;
	localparam logic [6:0]  WRAP_OFFSET    = 7'h40;
	localparam logic [6:0]  SMALL_MAX      = 7'h01;

	// Decoder states, Gray along primary -> secondary -> primary
	typedef enum logic [1:0] {
		CTCD_PRIMARY   = 2'b00,
		CTCD_SECONDARY = 2'b01,
		CTCD_HALTED    = 2'b11
	} ctcd_state_t;

	// Analog path control bits
	typedef struct packed {
		logic       flag11;
		logic       flag10;
		logic       sinx;
		logic [1:0] gain;
		logic       sync;
		logic       aux;
		logic       loopback;
		logic       hpf;
	} ctcd_ctrl_t;

	localparam ctcd_ctrl_t CTRL_RESET = '{flag11: 1'b0, flag10: 1'b0, sinx: 1'b0,
		gain: GAIN_RESET, sync: 1'b1, aux: 1'b0, loopback: 1'b0, hpf: 1'b1};

	// Timing registers as seen by the period counters
	typedef struct packed {
		logic [4:0] xmit_divider_a;
		logic [4:0] recv_divider_a;
		logic [5:0] xmit_a_trim;
		logic [5:0] recv_a_trim;
		logic [5:0] xmit_divider_b;
		logic [5:0] recv_divider_b;
	} ctcd_timing_t;

	localparam ctcd_timing_t TIMING_RESET = '{xmit_divider_a: A_DIV_RESET,
		recv_divider_a: A_DIV_RESET, xmit_a_trim: TRIM_RESET, recv_a_trim: TRIM_RESET,
		xmit_divider_b: B_DIV_RESET, recv_divider_b: B_DIV_RESET};
endpackage

/* rtl/ctcd_decoder.sv */
// Serial command word decoder for the codec timing and control registers
`timescale 1ns/1ns
// Overview of operation
// [RULE1] Selector 00 loads both 5-bit A dividers
// [RULE2] Selector 01 loads both signed 6-bit trims
// [RULE3] Selector 10 loads both 6-bit B dividers
// [RULE4] Selector 11: high-pass filter and loopback bits
// [RULE5] Control: auxiliary inputs and synchronous mode bits
// [RULE6] Control: two gain bits and sinx filter
// [RULE7] Control: flag pins follow D10, D11
// [RULE8] Reset sets registers for default conversion rates
// [RULE9] Synchronous mode times both sides from transmit
// [RULE10] Host keeps A dividers at 4/5 minimum
// [RULE11] B divider below 15 stops its converter
// [RULE12] Host keeps A plus/minus trim above 1
// [RULE13] A plus/minus trim 0 or 1 loads plain A
// [RULE14] Negative A plus trim wraps modulo 64
// [RULE15] A divider 0 or 1 shuts down device
// [RULE16] A divider too small halts serial port
// [RULE17] Lost communication holds last output value
// [RULE18] Host recovers by reset then reprogramming
// [RULE19] Host keeps output frames at least 40 us apart
// [RULE20] Reset: dividers 18, trims 01 hex
// [RULE21] Reset: documented default control state
// [RULE22] Secondary word follows primary ending 11 only
// [RULE23] Primary low bits pick add, subtract or plain
// [RULE24] Registers change only on complete secondary word
module ctcd_decoder
	import ctcd_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic         shift_clock_pin,
	input  wire logic         xmit_frame_sync_n,
	input  wire logic         host_to_codec_serial,
	input  wire logic         word_mode,
	output ctcd_timing_t      timing_regs,
	output ctcd_ctrl_t        analog_path_control,
	output logic              flag_out_ten,
	output logic              flag_out_eleven,
	output logic [13:0]       dac_word,
	output logic [5:0]        xmit_a_period,
	output logic [5:0]        recv_a_period,
	output logic [5:0]        recv_b_period,
	output logic              adc_stopped,
	output logic              dac_stopped,
	output logic              port_halted,
	output logic              shut_down,
	output logic              dac_hold
);

	// Pin synchronisers; first stages feed only second stages
	logic [1:0]   sck_sync_reg;
	logic [1:0]   fs_sync_reg;
	logic [1:0]   dat_sync_reg;
	logic [1:0]   wm_sync_reg;
	logic         sck_last_reg;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sck_sync_reg <= 2'h3; // Idle shift clock level, no false edge
			fs_sync_reg  <= 2'h3;
			dat_sync_reg <= 2'h0;
			wm_sync_reg  <= 2'h3;
			sck_last_reg <= 1'b1;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], shift_clock_pin};
			fs_sync_reg  <= {fs_sync_reg[0], xmit_frame_sync_n};
			dat_sync_reg <= {dat_sync_reg[0], host_to_codec_serial};
			wm_sync_reg  <= {wm_sync_reg[0], word_mode};
			sck_last_reg <= sck_sync_reg[1];
		end
	end

	// Bit strobe on a falling shift clock inside a frame
	wire          sck_fall   = sck_last_reg & ~sck_sync_reg[1];
	wire          bit_strobe = sck_fall & ~fs_sync_reg[1];
	wire          word_sel   = wm_sync_reg[1];

	// Shift register and bit count; byte mode simply spans two frames
	logic [15:0]  shift_reg;
	logic [4:0]   bit_cnt_reg;
	ctcd_state_t  state_reg;
	ctcd_state_t  state_next;
	wire          word_done  = bit_strobe && (bit_cnt_reg == LAST_BIT)
		&& (state_reg != CTCD_HALTED);
	wire [15:0]   word_in    = {shift_reg[14:0], dat_sync_reg[1]};
	wire [1:0]    word_sel_bits = word_in[1:0];
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			shift_reg   <= 16'h0000;
			bit_cnt_reg <= 5'h00;
		end else if (bit_strobe && state_reg != CTCD_HALTED) begin
			shift_reg   <= word_in;
			bit_cnt_reg <= word_done ? 5'h00 : bit_cnt_reg + 5'h01;
		end
	end

	// Word kind decode
	wire          pri_done   = word_done && state_reg == CTCD_PRIMARY;
	wire          sec_done   = word_done && state_reg == CTCD_SECONDARY; // [RULE24]
	wire          ld_a_div   = sec_done && word_sel_bits == SEL_A_DIV;
	wire          ld_trim    = sec_done && word_sel_bits == SEL_TRIM;
	wire          ld_b_div   = sec_done && word_sel_bits == SEL_B_DIV;
	wire          ld_ctrl    = sec_done && word_sel_bits == SEL_CTRL;

	// Fault checks on the live register contents
	ctcd_timing_t tim_reg;
	ctcd_ctrl_t   ctrl_reg;
	wire [4:0]    a_min      = word_sel ? A_MIN_WORD : A_MIN_BYTE; // [RULE16]
	wire          a_too_small = (tim_reg.xmit_divider_a < a_min)
		|| (tim_reg.recv_divider_a < a_min); // [RULE16]
	wire          a_dead     = (tim_reg.xmit_divider_a <= A_DEAD_MAX)
		|| (tim_reg.recv_divider_a <= A_DEAD_MAX); // [RULE15]

	// Sequencer: secondary only after a primary ending 11, halt is final
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CTCD_PRIMARY: begin
				if (a_too_small)
					state_next = CTCD_HALTED; // [RULE16]
				else if (pri_done && word_sel_bits == PRI_SECONDARY)
					state_next = CTCD_SECONDARY; // [RULE22]
			end
			CTCD_SECONDARY: begin
				if (a_too_small)
					state_next = CTCD_HALTED;
				else if (sec_done)
					state_next = CTCD_PRIMARY;
			end
			CTCD_HALTED: state_next = CTCD_HALTED;
			default: state_next = CTCD_HALTED;
		endcase
	end

	// Register file, written only by complete secondary words
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= CTCD_PRIMARY;
			tim_reg   <= TIMING_RESET; // [RULE8] [RULE20]
			ctrl_reg  <= CTRL_RESET; // [RULE21]
		end else begin
			state_reg <= state_next;
			if (ld_a_div) begin
				tim_reg.xmit_divider_a <= word_in[XA_MSB:XA_LSB]; // [RULE1]
				tim_reg.recv_divider_a <= word_in[RA_MSB:RA_LSB]; // [RULE1]
			end
			if (ld_trim) begin
				tim_reg.xmit_a_trim <= word_in[X6_MSB:X6_LSB]; // [RULE2]
				tim_reg.recv_a_trim <= word_in[R6_MSB:R6_LSB]; // [RULE2]
			end
			if (ld_b_div) begin
				tim_reg.xmit_divider_b <= word_in[X6_MSB:X6_LSB]; // [RULE3]
				tim_reg.recv_divider_b <= word_in[R6_MSB:R6_LSB]; // [RULE3]
			end
			if (ld_ctrl) begin
				ctrl_reg.hpf      <= word_in[C_HPF]; // [RULE4]
				ctrl_reg.loopback <= word_in[C_LOOP]; // [RULE4]
				ctrl_reg.aux      <= word_in[C_AUX]; // [RULE5]
				ctrl_reg.sync     <= word_in[C_SYNC]; // [RULE5]
				ctrl_reg.gain     <= word_in[C_GAIN_MSB:C_GAIN_LSB]; // [RULE6]
				ctrl_reg.sinx     <= word_in[C_SINX]; // [RULE6]
				ctrl_reg.flag10   <= word_in[C_FLAG10]; // [RULE7]
				ctrl_reg.flag11   <= word_in[C_FLAG11]; // [RULE7]
			end
		end
	end

	// Period adjust mode latched from each primary word unless an A divider is 0 or 1
	logic [1:0]   adj_reg;
	logic [13:0]  dac_reg;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			adj_reg <= PRI_PLAIN;
			dac_reg <= 14'h0000;
		end else if (pri_done && !a_dead) begin
			adj_reg <= word_sel_bits; // [RULE23]
			dac_reg <= word_in[DAC_MSB:DAC_LSB]; // [RULE17]
		end
	end

	// Receive timing source: transmit registers in synchronous mode
	wire [4:0]    rx_a_src   = ctrl_reg.sync ? tim_reg.xmit_divider_a
		: tim_reg.recv_divider_a; // [RULE9]
	wire [5:0]    rx_t_src   = ctrl_reg.sync ? tim_reg.xmit_a_trim
		: tim_reg.recv_a_trim; // [RULE9]
	wire [5:0]    rx_b_src   = ctrl_reg.sync ? tim_reg.xmit_divider_b
		: tim_reg.recv_divider_b; // [RULE9]

	// Trimmed A period with small-value and negative-value handling
	function automatic logic [5:0] ctcd_a_period(input logic [4:0] div,
		input logic [5:0] trim, input logic [1:0] adj);
		logic [6:0] sum;
		sum = 7'h00;
		if (adj == PRI_ADD)
			sum = {2'b00, div} + {trim[5], trim};
		else if (adj == PRI_SUB)
			sum = {2'b00, div} - {trim[5], trim};
		else
			sum = {2'b00, div};
		if (adj == PRI_PLAIN || adj == PRI_SECONDARY)
			ctcd_a_period = {1'b0, div};
		else if (!sum[6] && sum <= SMALL_MAX)
			ctcd_a_period = {1'b0, div}; // [RULE13]
		else if (sum[6])
			ctcd_a_period = 6'(sum + WRAP_OFFSET); // [RULE14]
		else
			ctcd_a_period = sum[5:0];
	endfunction

	wire [5:0]    tx_a_next  = ctcd_a_period(tim_reg.xmit_divider_a, tim_reg.xmit_a_trim,
		adj_reg);
	wire [5:0]    rx_a_next  = ctcd_a_period(rx_a_src, rx_t_src, adj_reg);
	wire          shut_next  = a_dead; // [RULE15]
	wire          halt_next  = state_next == CTCD_HALTED; // [RULE16]

	// Registered outputs
	logic         shut_reg;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			timing_regs         <= TIMING_RESET;
			analog_path_control <= CTRL_RESET;
			flag_out_ten        <= 1'b0;
			flag_out_eleven     <= 1'b0;
			dac_word            <= 14'h0000;
			xmit_a_period       <= {1'b0, A_DIV_RESET};
			recv_a_period       <= {1'b0, A_DIV_RESET};
			recv_b_period       <= B_DIV_RESET;
			adc_stopped         <= 1'b0;
			dac_stopped         <= 1'b0;
			port_halted         <= 1'b0;
			shut_reg            <= 1'b0;
			dac_hold            <= 1'b0;
		end else begin
			timing_regs         <= tim_reg;
			analog_path_control <= ctrl_reg;
			flag_out_ten        <= ctrl_reg.flag10; // [RULE7]
			flag_out_eleven     <= ctrl_reg.flag11; // [RULE7]
			dac_word            <= dac_reg;
			xmit_a_period       <= tx_a_next;
			recv_a_period       <= rx_a_next;
			recv_b_period       <= rx_b_src;
			adc_stopped         <= tim_reg.xmit_divider_b < B_MIN; // [RULE11]
			dac_stopped         <= tim_reg.recv_divider_b < B_MIN; // [RULE11]
			port_halted         <= halt_next;
			shut_reg            <= shut_reg | shut_next; // [RULE15]
			dac_hold            <= halt_next | shut_reg | shut_next; // [RULE17]
		end
	end
	assign shut_down = shut_reg;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_a_div_load: assert property (ld_a_div |=> tim_reg.xmit_divider_a == $past(word_in[13:9])
		&& tim_reg.recv_divider_a == $past(word_in[6:2])) // [RULE1]
		else $error("A divider load mismatch");
	a_trim_load: assert property (ld_trim |=> tim_reg.xmit_a_trim == $past(word_in[14:9])
		&& tim_reg.recv_a_trim == $past(word_in[7:2])) // [RULE2]
		else $error("trim load mismatch");
	a_b_div_load: assert property (ld_b_div |=> ##1 timing_regs.recv_divider_b
		== $past(word_in[7:2], 2)) // [RULE3]
		else $error("B divider load mismatch");
	a_ctrl_flags: assert property (ld_ctrl |=> ##1 flag_out_ten == $past(word_in[10], 2)
		&& analog_path_control.sync == $past(word_in[5], 2)) // [RULE5] [RULE7]
		else $error("control load mismatch");
	a_regs_stable: assert property (!sec_done |=> $stable(tim_reg) && $stable(ctrl_reg)) // [RULE24]
		else $error("register changed without secondary word");
	a_halt_sticky: assert property (port_halted |=> port_halted && !word_done) // [RULE16]
		else $error("halted port resumed");
	a_sec_after_pri: assert property (pri_done && !a_too_small |=> (state_reg == CTCD_SECONDARY)
		== ($past(word_sel_bits) == PRI_SECONDARY)) // [RULE22]
		else $error("secondary state not set by primary request");
	a_b_stop: assert property (tim_reg.recv_divider_b < B_MIN |=> dac_stopped) // [RULE11]
		else $error("output converter not stopped");
	a_sync_rx_src: assert property (ctrl_reg.sync |=> recv_b_period
		== $past(tim_reg.xmit_divider_b)) // [RULE9]
		else $error("receive timing not taken from transmit");
	a_shut_hold: assert property (shut_down |-> dac_hold && $stable(dac_reg)) // [RULE15] [RULE17]
		else $error("output changed while shut down");

	c_secondary_word: cover property (pri_done && word_sel_bits == PRI_SECONDARY ##[1:300] sec_done);
	c_ctrl_write: cover property (ld_ctrl);
	c_port_halt: cover property (!port_halted ##1 port_halted);
endmodule

/* test/codec_timing_command_decoder_tb_top.sv */
// Self-checking testbench for the serial command word decoder
`timescale 1ns/1ns
module codec_timing_command_decoder_tb_top
	import ctcd_pkg::*;
;
	logic         clock;
	logic         reset;
	logic         word_mode;
	logic         sclk;
	logic         fs_n;
	logic         sdata;
	ctcd_timing_t timing_regs;
	ctcd_ctrl_t   ctrl;
	logic         f10;
	logic         f11;
	logic [13:0]  dac_word;
	logic [5:0]   xa_per;
	logic [5:0]   ra_per;
	logic [5:0]   rb_per;
	logic         adc_stop;
	logic         dac_stop;
	logic         halted;
	logic         shut;
	logic         hold;
	ctcd_timing_t exp_t;
	ctcd_ctrl_t   exp_c;
	logic [13:0]  exp_dac;
	logic [1:0]   exp_adj;
	logic [15:0]  w;
	int           mismatches = 0;
	int           compares = 0;

	ctcd_decoder i_ctcd_decoder (.clock(clock), .reset(reset), .shift_clock_pin(sclk),
		.xmit_frame_sync_n(fs_n), .host_to_codec_serial(sdata), .word_mode(word_mode),
		.timing_regs(timing_regs), .analog_path_control(ctrl), .flag_out_ten(f10),
		.flag_out_eleven(f11), .dac_word(dac_word), .xmit_a_period(xa_per),
		.recv_a_period(ra_per), .recv_b_period(rb_per), .adc_stopped(adc_stop),
		.dac_stopped(dac_stop), .port_halted(halted), .shut_down(shut), .dac_hold(hold));

	ctcd_host_model i_ctcd_host_model (.clock(clock), .byte_mode(~word_mode),
		.shift_clock_pin(sclk), .xmit_frame_sync_n(fs_n), .host_to_codec_serial(sdata));

	// Clock generator, 100 ns period
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Expected A period counter load value
	function automatic logic [5:0] per(input logic [4:0] a, input logic [5:0] t,
		input logic [1:0] adj);
		int s;
		s = (adj == PRI_SUB) ? int'(a) - int'($signed(t)) : int'(a) + int'($signed(t));
		if (adj == PRI_PLAIN || adj == PRI_SECONDARY || s == 0 || s == 1)
			return {1'b0, a};
		return 6'(s < 0 ? s + 64 : s);
	endfunction

	// Shadow update for one secondary word
	function automatic void apply(input logic [15:0] s);
		case (s[1:0])
			2'h0: {exp_t.xmit_divider_a, exp_t.recv_divider_a} = {s[13:9], s[6:2]};
			2'h1: {exp_t.xmit_a_trim, exp_t.recv_a_trim} = {s[14:9], s[7:2]};
			2'h2: {exp_t.xmit_divider_b, exp_t.recv_divider_b} = {s[14:9], s[7:2]};
			default: exp_c = {s[11:9], s[7:2]};
		endcase
	endfunction

	task automatic check_all(input logic hlt);
		chk("timing_regs", timing_regs, exp_t);
		chk("control", ctrl, exp_c);
		chk("flags", {f11, f10}, {exp_c.flag11, exp_c.flag10});
		chk("dac_word", dac_word, exp_dac);
		if (!hlt) begin
			chk("xa_per", xa_per, per(exp_t.xmit_divider_a, exp_t.xmit_a_trim, exp_adj));
			chk("ra_per", ra_per, exp_c.sync ? per(exp_t.xmit_divider_a, exp_t.xmit_a_trim, exp_adj)
				: per(exp_t.recv_divider_a, exp_t.recv_a_trim, exp_adj));
			chk("rb_per", rb_per, exp_c.sync ? exp_t.xmit_divider_b : exp_t.recv_divider_b);
			chk("stopped", {adc_stop, dac_stop},
				{exp_t.xmit_divider_b < 6'h0F, exp_t.recv_divider_b < 6'h0F});
			chk("status", {halted, shut, hold}, 3'h0);
		end
	endtask

	// Primary ending 11, secondary, then a trailing primary
	task automatic step(input logic [15:0] s, input logic [1:0] adj, input logic rl,
		input logic dl);
		logic [15:0] p;
		p = 16'($urandom);
		i_ctcd_host_model.tick(180); // Pause of 18 us before the primary frame sync
		i_ctcd_host_model.send({p[15:2], PRI_SECONDARY});
		i_ctcd_host_model.send(s);
		if (rl) begin
			exp_dac = p[15:2];
			exp_adj = PRI_PLAIN;
			apply(s);
		end
		p = 16'($urandom);
		i_ctcd_host_model.send({p[15:2], adj});
		if (dl) begin
			exp_dac = p[15:2];
			exp_adj = adj;
		end
		i_ctcd_host_model.tick(4);
		check_all(!dl);
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		i_ctcd_host_model.tick(10);
		reset <= 1'b0;
		i_ctcd_host_model.tick(3);
		exp_t = {5'h12, 5'h12, 6'h01, 6'h01, 6'h12, 6'h12};
		exp_c = 9'h009; // High-pass in, synchronous, rest clear
		exp_dac = '0;
		exp_adj = PRI_PLAIN;
		check_all(0);
	endtask

	// Watchdog
	initial begin
		repeat (100000) @(posedge clock);
		mismatches++;
		conclude();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		word_mode = 1'b1;
		w = 16'($urandom(69));
		do_reset();
		step({2'h3, 5'h04, 2'h3, 5'h12, SEL_A_DIV}, PRI_ADD, 1, 1);
		step({1'h1, 6'h3B, 1'h1, 6'h3D, SEL_TRIM}, PRI_ADD, 1, 1);
		step({1'h0, 6'h03, 1'h0, 6'h03, SEL_TRIM}, PRI_SUB, 1, 1);
		step({1'h0, 6'h0F, 1'h0, 6'h0E, SEL_B_DIV}, PRI_PLAIN, 1, 1);
		for (int n = 0; n < 30; n++) begin
			w = 16'($urandom);
			if (w[1:0] == SEL_A_DIV && w[13:9] < 5'h05)
				w[13:9] = w[13:9] + 5'h05;
			if (w[1:0] == SEL_A_DIV && w[6:2] < 5'h05)
				w[6:2] = w[6:2] + 5'h05;
			if (w[1:0] == SEL_TRIM)
				{w[14:11], w[7:4]} = {{4{w[10]}}, {4{w[3]}}}; // Small trims keep A +/- trim > 1
			step(w, 2'($urandom_range(2, 0)), 1, 1);
		end
		// Word after a plain primary is another primary
		w = 16'($urandom);
		i_ctcd_host_model.send({w[15:2], PRI_PLAIN});
		i_ctcd_host_model.tick(180);
		i_ctcd_host_model.send({w[13:0], SEL_B_DIV});
		exp_dac = w[13:0];
		exp_adj = PRI_SUB;
		i_ctcd_host_model.tick(4);
		check_all(0);
		step({2'h0, 5'h05, 2'h0, 5'h05, SEL_A_DIV}, PRI_PLAIN, 1, 1); // Legal in byte mode
		word_mode <= 1'b0;
		step({2'h0, 5'h05, 2'h0, 5'h05, SEL_A_DIV}, PRI_ADD, 1, 1);
		step({2'h0, 5'h04, 2'h0, 5'h12, SEL_A_DIV}, PRI_PLAIN, 1, 0);
		step(16'hFFFF, PRI_ADD, 0, 0);
		chk("halted", {halted, hold}, 2'h3);
		word_mode <= 1'b1;
		do_reset();
		step({2'h0, 5'h01, 2'h0, 5'h12, SEL_A_DIV}, PRI_PLAIN, 1, 0);
		chk("shut_down", {shut, hold}, 2'h3);
		do_reset();
		conclude();
	end
endmodule

/* test/ctcd_host_model.sv */
// Behavioural host processor that frames command words onto the serial pins
`timescale 1ns/1ns
module ctcd_host_model (
	input  wire logic clock,
	input  wire logic byte_mode,
	output logic      shift_clock_pin,
	output logic      xmit_frame_sync_n,
	output logic      host_to_codec_serial
);
	// Idle pins: shift clock high and still, frame off
	initial begin
		shift_clock_pin = 1'b1;
		xmit_frame_sync_n = 1'b1;
		host_to_codec_serial = 1'b0;
	end

	// Waits a number of system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Sends one word D15 first, two 8-bit frames in byte mode
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			if (i == 15 || (byte_mode && i == 7)) begin
				xmit_frame_sync_n <= 1'b0;
				tick(4);
			end
			host_to_codec_serial <= w[i];
			tick(4);
			shift_clock_pin <= 1'b0;
			tick(4);
			shift_clock_pin <= 1'b1;
			if (i == 0 || (byte_mode && i == 8)) begin
				xmit_frame_sync_n <= 1'b1;
				host_to_codec_serial <= ~w[i]; // Released line shows no stale bit
				tick(32); // Four shift cycles between words
			end
		end
	endtask
endmodule
